// File: rtl/tdas_pkg.sv
// Summary of operation
// - Hardware shut-off input high stops optical output; low allows transmission.
// - After a transmitter fault, cycling the shut-off input resets the fault.
// - Undriven shut-off input keeps transmitter off until host drives it low.
// - Software shut-off bit 6 of byte 110, written by host over serial bus.
// - Shut-off state readable as status bit 7 of byte 110.
// - Transmitter off when software bit or hardware input is high.
// - Host reads real-time power, temperature, supply and bias monitor values.
// - Shut-off and loss-of-signal flags mirrored into serial memory map.
// - Laser fault latches fault output, disables laser, shown at bit 2.
// - Loss-of-signal output high for unusable input, mirrored at bit 1.
package tdas_pkg;

	// ********************************
	// Serial space layout
	// ********************************
	localparam logic [6:0] DEV_ADDR      = 7'h51;
	localparam logic [7:0] STATUS_OFFSET = 8'h6E;
	localparam logic [7:0] MON_BASE      = 8'h60;
	localparam int         MON_BYTES     = 10;
	localparam int         MON_BITS      = MON_BYTES * 8;
	localparam logic [3:0] BYTE_BITS     = 4'h8;

	// ********************************
	// Status byte fields
	// ********************************
	localparam int BIT_HW_OFF   = 7;
	localparam int BIT_SOFT_OFF = 6;
	localparam int BIT_FAULT    = 2;
	localparam int BIT_LOS      = 1;

	// ********************************
	// Input synchroniser lanes
	// ********************************
	localparam int         LANES      = 5;
	localparam int         LANE_SCL   = 0;
	localparam int         LANE_SDA   = 1;
	localparam int         LANE_TDIS  = 2;
	localparam int         LANE_FAULT = 3;
	localparam int         LANE_LOS   = 4;
	// Bus idles high; shut-off input pulled up
	localparam logic [4:0] SYNC_RESET = 5'h07;

	localparam logic       SOFT_OFF_RESET = 1'b0;

	typedef enum logic [6:0] {
		S_IDLE  = 7'h01,
		S_ADDR  = 7'h02,
		S_AACK  = 7'h04,
		S_WDATA = 7'h08,
		S_WACK  = 7'h10,
		S_RDATA = 7'h20,
		S_RACK  = 7'h40
	} tdas_state_t;

endpackage

// File: rtl/tdas_mem.sv
module tdas_mem #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	// Clock and reset
	input  wire logic          clock,
	input  wire logic          sys_rst,
	// Write port
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [DW-1:0] wr_data,
	// Read port
	input  wire logic [AW-1:0] rd_addr,
	output logic      [DW-1:0] rd_data
);

	generate
		if (AW < 1 || AW > 8 || DW < 1)
			$error("tdas_mem: unsupported width");
	endgenerate

	logic [DW-1:0] store [0:(1<<AW)-1];
	logic [DW-1:0] rd_next;

	always_comb
	begin
		rd_next = store[rd_addr];
	end

	always_ff @(posedge clock)
	begin
		if (wr_en)
			store[wr_addr] <= wr_data;
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			rd_data <= '0;
		else
			rd_data <= rd_next;
	end

endmodule

// File: rtl/tdas_top.sv
module tdas_top (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// Two-wire management bus
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	// Transmitter control pins
	input  wire logic        tx_disable_pin,
	input  wire logic        laser_fault_pin,
	output logic             laser_enable,
	output logic             tx_fault_out,
	// Receiver status
	input  wire logic        los_pin,
	output logic             receive_signal_lost,
	// Real-time monitor values
	input  wire logic [15:0] mon_temp,
	input  wire logic [15:0] mon_vcc,
	input  wire logic [15:0] mon_bias,
	input  wire logic [15:0] mon_tx_power,
	input  wire logic [15:0] mon_rx_power
);

	// ********************************
	// Address decode helpers
	// ********************************
	function automatic logic is_monitor(input logic [7:0] a);
		is_monitor = (a >= tdas_pkg::MON_BASE) &&
			(a < tdas_pkg::MON_BASE + 8'(tdas_pkg::MON_BYTES));
	endfunction

	function automatic logic [7:0] mon_byte(
		input logic [tdas_pkg::MON_BITS-1:0] snap,
		input logic [7:0] a);
		logic [7:0] idx;
		idx = a - tdas_pkg::MON_BASE;
		mon_byte = 8'h00;
		for (int i = 0; i < tdas_pkg::MON_BYTES; i++)
			if (idx == 8'(i))
				mon_byte = snap[tdas_pkg::MON_BITS-1-8*i -: 8];
	endfunction

	// ********************************
	// Pin synchronisers
	// ********************************
	logic [4:0] pins;
	logic [4:0] s1_reg, s2_reg, s3_reg;
	logic [4:0] lvl_reg, lvl_next, prev_reg;

	assign pins = {los_pin, laser_fault_pin, tx_disable_pin, sda_in, scl_in};

	genvar g;
	generate
		for (g = 0; g < tdas_pkg::LANES; g++)
		begin : g_sync
			assign lvl_next[g] = (s2_reg[g] == s3_reg[g]) ?
				s2_reg[g] : lvl_reg[g];
			always_ff @(posedge clock or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					s1_reg[g]   <= tdas_pkg::SYNC_RESET[g];
					s2_reg[g]   <= tdas_pkg::SYNC_RESET[g];
					s3_reg[g]   <= tdas_pkg::SYNC_RESET[g];
					lvl_reg[g]  <= tdas_pkg::SYNC_RESET[g];
					prev_reg[g] <= tdas_pkg::SYNC_RESET[g];
				end
				else
				begin
					s1_reg[g]   <= pins[g];
					s2_reg[g]   <= s1_reg[g];
					s3_reg[g]   <= s2_reg[g];
					lvl_reg[g]  <= lvl_next[g];
					prev_reg[g] <= lvl_reg[g];
				end
			end
		end
	endgenerate

	logic scl, sda, scl_p, sda_p, hw_off, hw_prev, fault_lvl, los_lvl;
	assign scl       = lvl_reg[tdas_pkg::LANE_SCL];
	assign sda       = lvl_reg[tdas_pkg::LANE_SDA];
	assign scl_p     = prev_reg[tdas_pkg::LANE_SCL];
	assign sda_p     = prev_reg[tdas_pkg::LANE_SDA];
	assign hw_off    = lvl_reg[tdas_pkg::LANE_TDIS];
	assign hw_prev   = prev_reg[tdas_pkg::LANE_TDIS];
	assign fault_lvl = lvl_reg[tdas_pkg::LANE_FAULT];
	assign los_lvl   = lvl_reg[tdas_pkg::LANE_LOS];

	logic scl_rise, scl_fall, bus_start, bus_stop, hw_rise;
	assign scl_rise  = scl & ~scl_p;
	assign scl_fall  = ~scl & scl_p;
	assign bus_start = scl & scl_p & sda_p & ~sda;
	assign bus_stop  = scl & scl_p & ~sda_p & sda;
	assign hw_rise   = hw_off & ~hw_prev;

	// ********************************
	// Transmitter control and status
	// ********************************
	logic       soft_reg, soft_next, fault_reg, fault_next;
	logic       laser_reg, laser_next, los_reg;
	logic [7:0] status_byte;
	logic       soft_wr;
	logic [7:0] sh_reg;

	always_comb
	begin
		soft_next  = soft_wr ? sh_reg[tdas_pkg::BIT_SOFT_OFF] : soft_reg;
		// Set wins over the clearing toggle
		fault_next = fault_lvl ? 1'b1 : (hw_rise ? 1'b0 : fault_reg);
		laser_next = ~(hw_off | soft_reg | fault_reg);
		status_byte = 8'h00;
		status_byte[tdas_pkg::BIT_HW_OFF]   = hw_off;
		status_byte[tdas_pkg::BIT_SOFT_OFF] = soft_reg;
		status_byte[tdas_pkg::BIT_FAULT]    = fault_reg;
		status_byte[tdas_pkg::BIT_LOS]      = los_lvl;
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			soft_reg  <= tdas_pkg::SOFT_OFF_RESET;
			fault_reg <= 1'b0;
			laser_reg <= 1'b0;
			los_reg   <= 1'b0;
		end
		else
		begin
			soft_reg  <= soft_next;
			fault_reg <= fault_next;
			laser_reg <= laser_next;
			los_reg   <= los_lvl;
		end
	end

	assign laser_enable        = laser_reg;
	assign tx_fault_out        = fault_reg;
	assign receive_signal_lost = los_reg;

	// ********************************
	// Serial slave
	// ********************************
	tdas_pkg::tdas_state_t state_reg, state_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [7:0] sh_next, ptr_reg, ptr_next, rd_byte, mem_rdata;
	logic       first_reg, first_next, rw_reg, rw_next;
	logic       nack_reg, nack_next, oe_reg, oe_next, wr_en, load;
	logic [tdas_pkg::MON_BITS-1:0] snap_reg, snap_next;

	always_comb
	begin
		// Freeze during a transfer so multi-byte values stay coherent
		snap_next = (state_reg == tdas_pkg::S_IDLE) ?
			{mon_temp, mon_vcc, mon_bias, mon_tx_power, mon_rx_power} :
			snap_reg;
		if (ptr_reg == tdas_pkg::STATUS_OFFSET)
			rd_byte = status_byte;
		else if (is_monitor(ptr_reg))
			rd_byte = mon_byte(snap_reg, ptr_reg);
		else
			rd_byte = mem_rdata;
	end

	always_comb
	begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		sh_next    = sh_reg;
		ptr_next   = ptr_reg;
		first_next = first_reg;
		rw_next    = rw_reg;
		nack_next  = nack_reg;
		oe_next    = oe_reg;
		wr_en      = 1'b0;
		soft_wr    = 1'b0;
		load       = 1'b0;
		if (bus_stop)
		begin
			state_next = tdas_pkg::S_IDLE;
			oe_next    = 1'b0;
		end
		else if (bus_start)
		begin
			state_next = tdas_pkg::S_ADDR;
			cnt_next   = 4'h0;
			first_next = 1'b1;
			oe_next    = 1'b0;
		end
		else
		begin
			if (scl_rise && (state_reg == tdas_pkg::S_ADDR ||
				state_reg == tdas_pkg::S_WDATA))
			begin
				sh_next  = {sh_reg[6:0], sda};
				cnt_next = cnt_reg + 4'h1;
			end
			if (scl_rise && state_reg == tdas_pkg::S_RDATA)
				cnt_next = cnt_reg + 4'h1;
			if (scl_rise && state_reg == tdas_pkg::S_RACK)
				nack_next = sda;
			if (scl_fall)
			begin
				case (state_reg)
					tdas_pkg::S_ADDR:
						if (cnt_reg == tdas_pkg::BYTE_BITS)
						begin
							cnt_next = 4'h0;
							rw_next  = sh_reg[0];
							if (sh_reg[7:1] == tdas_pkg::DEV_ADDR)
							begin
								state_next = tdas_pkg::S_AACK;
								oe_next    = 1'b1;
							end
							else
								state_next = tdas_pkg::S_IDLE;
						end
					tdas_pkg::S_AACK:
						if (rw_reg)
							load = 1'b1;
						else
						begin
							state_next = tdas_pkg::S_WDATA;
							oe_next    = 1'b0;
						end
					tdas_pkg::S_WDATA:
						if (cnt_reg == tdas_pkg::BYTE_BITS)
						begin
							cnt_next   = 4'h0;
							state_next = tdas_pkg::S_WACK;
							oe_next    = 1'b1;
							first_next = 1'b0;
							if (first_reg)
								ptr_next = sh_reg;
							else
							begin
								ptr_next = ptr_reg + 8'h01;
								if (ptr_reg == tdas_pkg::STATUS_OFFSET)
									soft_wr = 1'b1;
								else if (!is_monitor(ptr_reg))
									wr_en = 1'b1;
							end
						end
					tdas_pkg::S_WACK:
					begin
						state_next = tdas_pkg::S_WDATA;
						oe_next    = 1'b0;
					end
					tdas_pkg::S_RDATA:
						if (cnt_reg == tdas_pkg::BYTE_BITS)
						begin
							cnt_next   = 4'h0;
							state_next = tdas_pkg::S_RACK;
							oe_next    = 1'b0;
						end
						else
						begin
							sh_next = {sh_reg[6:0], 1'b0};
							oe_next = ~sh_reg[6];
						end
					tdas_pkg::S_RACK:
						if (nack_reg)
							state_next = tdas_pkg::S_IDLE;
						else
							load = 1'b1;
					default:
						state_next = tdas_pkg::S_IDLE;
				endcase
			end
			if (load)
			begin
				state_next = tdas_pkg::S_RDATA;
				sh_next    = rd_byte;
				oe_next    = ~rd_byte[7];
				ptr_next   = ptr_reg + 8'h01;
			end
		end
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_reg <= tdas_pkg::S_IDLE;
			cnt_reg   <= 4'h0;
			sh_reg    <= 8'h00;
			ptr_reg   <= 8'h00;
			first_reg <= 1'b1;
			rw_reg    <= 1'b0;
			nack_reg  <= 1'b0;
			oe_reg    <= 1'b0;
			snap_reg  <= '0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			sh_reg    <= sh_next;
			ptr_reg   <= ptr_next;
			first_reg <= first_next;
			rw_reg    <= rw_next;
			nack_reg  <= nack_next;
			oe_reg    <= oe_next;
			snap_reg  <= snap_next;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe  = oe_reg;

	tdas_mem #(.AW(8), .DW(8)) u_mem (
		.clock   (clock),
		.sys_rst (sys_rst),
		.wr_en   (wr_en),
		.wr_addr (ptr_reg),
		.wr_data (sh_reg),
		.rd_addr (ptr_reg),
		.rd_data (mem_rdata)
	);

	// ********************************
	// Checks
	// ********************************
	// Monitor byte the pointer selects, for the read check
	logic [7:0] mon_sel;
	assign mon_sel = mon_byte(snap_reg, ptr_reg);

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	hw_shut_a: assert property (hw_off |=> !laser_enable)
		else $error("laser on while hardware shut-off high");
	or_shut_a: assert property ((soft_reg || hw_off) |=> !laser_enable)
		else $error("laser on while a shut-off source is high");
	drive_low_a: assert property ($fell(hw_off) |->
		!$past(s2_reg[tdas_pkg::LANE_TDIS]) &&
		!$past(s3_reg[tdas_pkg::LANE_TDIS]))
		else $error("shut-off released without pin driven low");
	fault_clear_a: assert property (
		(fault_reg && hw_rise && !fault_lvl) |=> !fault_reg)
		else $error("fault not cleared by shut-off cycle");
	fault_hold_a: assert property ((fault_reg && !hw_rise) |=>
		fault_reg && !laser_enable)
		else $error("fault latch lost or laser enabled");
	soft_write_a: assert property (soft_wr |=>
		soft_reg == $past(sh_reg[tdas_pkg::BIT_SOFT_OFF]) ##1
		(!soft_reg || !laser_enable))
		else $error("software shut-off write not applied");
	status_off_a: assert property ($changed(hw_off) |->
		status_byte[tdas_pkg::BIT_HW_OFF] != $past(hw_off))
		else $error("status bit does not follow shut-off");
	los_mirror_a: assert property (los_lvl |=>
		receive_signal_lost && $past(status_byte[tdas_pkg::BIT_LOS]))
		else $error("loss of signal not mirrored");
	status_read_a: assert property ((load &&
		ptr_reg == tdas_pkg::STATUS_OFFSET) |=> sh_reg == $past(status_byte))
		else $error("status byte not loaded for read");
	mon_read_a: assert property ((load && is_monitor(ptr_reg)) |=>
		sh_reg == $past(mon_sel))
		else $error("monitor byte not loaded for read");

	soft_set_c:  cover property (soft_wr && sh_reg[tdas_pkg::BIT_SOFT_OFF]);
	fault_clr_c: cover property (fault_reg ##1 !fault_reg);
	mon_read_c:  cover property (load && is_monitor(ptr_reg));
	enable_c:    cover property ($rose(laser_enable));

endmodule

// File: test/tdas_host.sv
module tdas_host (
	// Clock
	input  wire logic clock,
	// Two-wire bus
	input  wire logic sda,
	output logic      scl,
	output logic      sda_drv
);
	timeunit 1ns;
	timeprecision 1ps;

	localparam int H = 5;

	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	// ********************************
	// Bus phases, changed on falling clock edge
	// ********************************
	task automatic gap();
		repeat (H) @(negedge clock);
	endtask

	task automatic bit_io(input logic b, output logic r);
		sda_drv = b;
		gap();
		scl = 1'b1;
		gap();
		r = sda;
		scl = 1'b0;
		gap();
	endtask

	task automatic start();
		sda_drv = 1'b1;
		gap();
		scl = 1'b1;
		gap();
		sda_drv = 1'b0;
		gap();
		scl = 1'b0;
		gap();
	endtask

	task automatic stop();
		sda_drv = 1'b0;
		gap();
		scl = 1'b1;
		gap();
		sda_drv = 1'b1;
		gap();
	endtask

	task automatic wr(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask

	// Master acks all but the last byte
	task automatic rd(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask
endmodule

// File: test/tb_top.sv
`define CHK(got, exp) \
	begin \
		n_tests++; \
		if ((got) !== (exp)) \
		begin \
			errors++; \
			$display("[FAIL] %0t got %0h exp %0h", $time, got, exp); \
		end \
	end

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [4:0][15:0] MV = {16'h7C8D, 16'h5A6B, 16'h1E2F,
		16'hC3D4, 16'hA1B2};

	logic       clock = 1'b0;
	logic       sys_rst = 1'b1;
	logic       scl, sda_drv, sda, sda_out, sda_oe;
	logic       tx_pin = 1'b1;
	logic       fault_pin = 1'b0;
	logic       los_pin = 1'b0;
	logic       laser_enable, tx_fault_out, receive_signal_lost;
	logic [7:0] rb [10];
	int         errors = 0;
	int         n_tests = 0;
	int         cyc = 0;

	// Open-drain wire with pull-up
	assign sda = sda_drv & !(sda_oe & !sda_out);

	always #5 clock = ~clock;

	tdas_host i_host (.clock(clock), .sda(sda), .scl(scl),
		.sda_drv(sda_drv));

	tdas_top i_dut (.clock(clock), .sys_rst(sys_rst), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.tx_disable_pin(tx_pin), .laser_fault_pin(fault_pin),
		.laser_enable(laser_enable), .tx_fault_out(tx_fault_out),
		.los_pin(los_pin), .receive_signal_lost(receive_signal_lost),
		.mon_temp(MV[0]), .mon_vcc(MV[1]), .mon_bias(MV[2]),
		.mon_tx_power(MV[3]), .mon_rx_power(MV[4]));

	// ********************************
	// Helpers
	// ********************************
	task automatic finish_test();
		$display("errors %0d tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic settle();
		repeat (8) @(negedge clock);
	endtask

	task automatic reg_wr(input logic [7:0] p, input logic [7:0] d);
		logic a;
		i_host.start();
		i_host.wr({tdas_pkg::DEV_ADDR, 1'b0}, a);
		`CHK(a, 1'b1)
		i_host.wr(p, a);
		`CHK(a, 1'b1)
		i_host.wr(d, a);
		`CHK(a, 1'b1)
		i_host.stop();
	endtask

	task automatic reg_rd(input logic [7:0] p, input int n);
		logic a;
		i_host.start();
		i_host.wr({tdas_pkg::DEV_ADDR, 1'b0}, a);
		`CHK(a, 1'b1)
		i_host.wr(p, a);
		`CHK(a, 1'b1)
		i_host.start();
		i_host.wr({tdas_pkg::DEV_ADDR, 1'b1}, a);
		`CHK(a, 1'b1)
		for (int i = 0; i < n; i++)
			i_host.rd(i == n - 1, rb[i]);
		i_host.stop();
	endtask

	task automatic chk_stat(input logic [7:0] e);
		reg_rd(tdas_pkg::STATUS_OFFSET, 1);
		`CHK(rb[0], e)
	endtask

	// ********************************
	// Scenarios
	// ********************************
	task automatic t_default();
		settle();
		`CHK(laser_enable, 1'b0)
		chk_stat(8'h80);
		tx_pin = 1'b0;
		settle();
		`CHK(laser_enable, 1'b1)
		chk_stat(8'h00);
	endtask

	task automatic t_soft();
		reg_wr(tdas_pkg::STATUS_OFFSET, 8'h40);
		`CHK(laser_enable, 1'b0)
		chk_stat(8'h40);
		// Only the soft bit is writable
		reg_wr(tdas_pkg::STATUS_OFFSET, 8'hBF);
		`CHK(laser_enable, 1'b1)
		chk_stat(8'h00);
	endtask

	task automatic t_fault();
		fault_pin = 1'b1;
		settle();
		`CHK(tx_fault_out, 1'b1)
		`CHK(laser_enable, 1'b0)
		chk_stat(8'h04);
		fault_pin = 1'b0;
		settle();
		`CHK(tx_fault_out, 1'b1)
		// Only pin assertion of the run, so spacing is met
		tx_pin = 1'b1;
		settle();
		chk_stat(8'h80);
		tx_pin = 1'b0;
		settle();
		`CHK(tx_fault_out, 1'b0)
		`CHK(laser_enable, 1'b1)
	endtask

	task automatic t_los();
		los_pin = 1'b1;
		settle();
		`CHK(receive_signal_lost, 1'b1)
		chk_stat(8'h02);
		los_pin = 1'b0;
		settle();
		`CHK(receive_signal_lost, 1'b0)
	endtask

	task automatic t_mon();
		reg_rd(tdas_pkg::MON_BASE, 10);
		for (int i = 0; i < 10; i++)
			`CHK(rb[i], i[0] ? MV[i/2][7:0] : MV[i/2][15:8])
	endtask

	task automatic t_mem();
		logic a;
		// Foreign address is not answered
		i_host.start();
		i_host.wr({tdas_pkg::DEV_ADDR ^ 7'h01, 1'b0}, a);
		`CHK(a, 1'b0)
		i_host.stop();
		// Plain byte stores and reads back
		reg_wr(8'h10, 8'h5A);
		reg_rd(8'h10, 1);
		`CHK(rb[0], 8'h5A)
		// Monitor bytes ignore writes
		reg_wr(tdas_pkg::MON_BASE, 8'h00);
		reg_rd(tdas_pkg::MON_BASE, 1);
		`CHK(rb[0], MV[0][15:8])
	endtask

	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			errors++;
			finish_test();
		end
	end

	initial
	begin
		repeat (20) @(negedge clock);
		sys_rst = 1'b0;
		t_default();
		t_soft();
		t_fault();
		t_los();
		t_mon();
		t_mem();
		finish_test();
	end
endmodule
